// File: src/ados_pkg.sv
// Constants shared by the output stage and its dither generator.
// Assumes a 40 MHz APB clock and 32-bit APB data.
package ados_pkg;
	localparam int          DATA_W       = 16;
	localparam int          DITHER_W     = 8;
	localparam int          LFSR_W       = 23;
	localparam int          LFSR_TAP_A   = 22;
	localparam int          LFSR_TAP_B   = 17;
	localparam logic [22:0] LFSR_SEED    = 23'h2A5A5B;
	localparam int          ADDR_W       = 8;
	localparam int          SYNC_STAGES  = 2;

	// Register byte offsets
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_STATUS   = 8'h04;
	localparam logic [7:0]  OFS_MASK     = 8'h08;
	localparam logic [7:0]  OFS_LAST     = 8'h0C;
	localparam logic [7:0]  OFS_COUNT    = 8'h10;

	// Control fields
	localparam int          CTRL_SCRAMBLE = 0;
	localparam int          CTRL_TWOS     = 1;
	localparam int          CTRL_DITHER   = 2;
	localparam int          CTRL_W        = 3;
	localparam logic [2:0]  CTRL_RESET    = 3'h0;

	// Status and mask fields
	localparam int          ST_SAMPLE    = 0;
	localparam int          ST_RANGE     = 1;
	localparam int          ST_W         = 2;
	localparam logic [1:0]  MASK_RESET   = 2'h0;

	// Last-word register layout
	localparam int          LAST_FLAG    = 16;

	localparam logic [31:0] RD_ZERO      = 32'h0000_0000;
endpackage : ados_pkg

// File: src/ados_dither_if.sv
// Carrier between the output stage and its dither generator.
// Assumes both ends run on the APB clock.
`timescale 1ns/10ps
interface ados_dither_if #(
	parameter int W = 8
);
	logic         step;
	logic         enable;
	logic [W-1:0] value;

	modport gen  (input step, input enable, output value);
	modport user (output step, output enable, input value);
endinterface : ados_dither_if

// File: src/ados_dither_gen.sv
// Long-sequence pseudo-random source for the dither path.
// Assumes step is a one-cycle pulse on the APB clock.
`timescale 1ns/10ps
module ados_dither_gen
	import ados_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	ados_dither_if.gen bus
);
	logic [LFSR_W-1:0] state;
	logic [DITHER_W-1:0] value_q;

	// Advances once per accepted sample while dither is on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= LFSR_SEED;
		end else if (bus.step && bus.enable) begin
			state <= {state[LFSR_W-2:0], state[LFSR_TAP_A] ^ state[LFSR_TAP_B]}; // see R12
		end
	end

	// Registered value, zero while dither is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_q <= '0;
		end else if (bus.enable) begin
			value_q <= state[DITHER_W-1:0]; // see R11
		end else begin
			value_q <= '0;
		end
	end

	assign bus.value = value_q;

	lfsr_alive_a: assert property (@(posedge pclk) disable iff (!presetn) // see R12
		state != '0)
		else $error("dither generator stuck at zero");
endmodule : ados_dither_gen

// File: src/ados_output_stage.sv
// Digital output stage: result word, range flag, output clock pair, dither.
// Assumes an APB master on pclk and a sample strobe slower than pclk / 4.
//
// Function
// R01 - one 16-bit word per strobe period
// R02 - range flag high when input out of range
// R03 - delayed strobe out, true and complement
// R04 - true clock falls as data update
// R05 - capture latches on true rise
// R06 - capture syncs using output clock pair (the capture model uses the true clock only)
// R07 - scramble XORs LSB into upper bits
// R08 - capture XORs LSB back to descramble
// R09 - scramble leaves LSB, flag, clocks alone
// R10 - scramble only while enable is high
// R11 - dither optional, off unless selected
// R12 - pseudo-random dither subtracted from result
// R13 - offset binary or two's complement select
// R14 - format and dither before scramble, aligned
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
module ados_output_stage
	import ados_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	output logic                     irq,
	input  wire logic                sample_strobe_in,
	input  wire logic [DATA_W-1:0]   conv_result,
	input  wire logic                conv_over,
	input  wire logic                conv_under,
	output logic      [DATA_W-1:0]   data_out,
	output logic                     range_flag,
	output logic                     sample_clock_out_true,
	output logic                     sample_clock_out_comp,
	output logic      [DITHER_W-1:0] dither_dac
);

	function automatic logic [DATA_W-1:0] ados_format(input logic [DATA_W-1:0] w,
		input logic twos);
		ados_format = twos ? {~w[DATA_W-1], w[DATA_W-2:0]} : w; // see R13
	endfunction : ados_format

	function automatic logic [DATA_W-1:0] ados_scramble(input logic [DATA_W-1:0] w,
		input logic en);
		ados_scramble = en ? {w[DATA_W-1:1] ^ {(DATA_W-1){w[0]}}, w[0]} : w; // see R07, R09
	endfunction : ados_scramble

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Synchronisers for strobe and analogue-side result
	logic [SYNC_STAGES-1:0] strobe_sync;
	logic                   strobe_prev;
	logic [DATA_W-1:0]      result_s1;
	logic [DATA_W-1:0]      result_s2;
	logic [1:0]             range_s1;
	logic [1:0]             range_s2;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_sync <= '0;
			strobe_prev <= 1'b0;
		end else begin
			strobe_sync <= {strobe_sync[SYNC_STAGES-2:0], sample_strobe_in};
			strobe_prev <= strobe_sync[SYNC_STAGES-1];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_s1 <= '0;
			result_s2 <= '0;
			range_s1  <= '0;
			range_s2  <= '0;
		end else begin
			result_s1 <= conv_result;
			result_s2 <= result_s1;
			range_s1  <= {conv_over, conv_under};
			range_s2  <= range_s1;
		end
	end

	logic strobe_rise;
	logic strobe_fall;

	assign strobe_rise = strobe_sync[SYNC_STAGES-1] & ~strobe_prev;
	assign strobe_fall = ~strobe_sync[SYNC_STAGES-1] & strobe_prev;

	// Control register
	logic [CTRL_W-1:0] ctrl;
	logic              scramble_enable;
	logic              format_twos;
	logic              dither_enable;

	assign scramble_enable = ctrl[CTRL_SCRAMBLE];
	assign format_twos     = ctrl[CTRL_TWOS];
	assign dither_enable   = ctrl[CTRL_DITHER];

	// APB decode
	logic wr_go;
	logic setup;

	assign setup = psel & ~penable;
	assign wr_go = psel & penable & pready & pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET;
		end else if (wr_go && paddr == OFS_CTRL) begin
			ctrl <= pwdata[CTRL_W-1:0]; // see R10
		end
	end

	// Dither generator
	ados_dither_if #(.W(DITHER_W)) dith_bus ();

	assign dith_bus.step   = strobe_rise;
	assign dith_bus.enable = dither_enable;
	assign dither_dac      = dith_bus.value;

	ados_dither_gen u_dither (
		.pclk    (pclk),
		.presetn (presetn),
		.bus     (dith_bus.gen)
	);

	// Word path: subtract dither, format, then scramble
	logic [DATA_W-1:0] next_plain;
	logic [DATA_W-1:0] next_word;
	logic [DATA_W-1:0] dither_sub;
	logic [DATA_W-1:0] plain_word;

	always_comb begin
		dither_sub = dither_enable ? {{(DATA_W-DITHER_W){1'b0}}, dith_bus.value} : '0;
		next_plain = ados_format(DATA_W'(result_s2 - dither_sub), format_twos); // see R12
		next_word  = ados_scramble(next_plain, scramble_enable); // see R14
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_out   <= '0;
			plain_word <= '0;
			range_flag <= 1'b0;
		end else if (strobe_rise) begin
			data_out   <= next_word; // see R01
			plain_word <= next_plain;
			range_flag <= |range_s2; // see R02
		end
	end

	// Output clock pair follows the strobe, true clock falling with each update
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_clock_out_true <= 1'b1;
			sample_clock_out_comp <= 1'b0;
		end else if (strobe_rise) begin
			sample_clock_out_true <= 1'b0; // see R04
			sample_clock_out_comp <= 1'b1; // see R03
		end else if (strobe_fall) begin
			sample_clock_out_true <= 1'b1;
			sample_clock_out_comp <= 1'b0;
		end
	end

	// Sample counter and last word
	logic [31:0] sample_count;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_count <= '0;
		end else if (wr_go && paddr == OFS_COUNT) begin
			sample_count <= '0;
		end else if (strobe_rise) begin
			sample_count <= sample_count + 32'h0000_0001;
		end
	end

	// Interrupt status, write one to clear, set wins
	logic [ST_W-1:0] status;
	logic [ST_W-1:0] mask;
	logic [ST_W-1:0] status_set;
	logic [ST_W-1:0] status_clr;

	assign status_set = {strobe_rise & (|range_s2), strobe_rise};
	assign status_clr = (wr_go && paddr == OFS_STATUS) ? pwdata[ST_W-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= '0;
		end else begin
			status <= (status & ~status_clr) | status_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= MASK_RESET;
		end else if (wr_go && paddr == OFS_MASK) begin
			mask <= pwdata[ST_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
		end
	end

	// Read mux, registered during setup
	logic [31:0] next_rdata;
	logic        next_err;

	always_comb begin
		next_rdata = RD_ZERO;
		next_err   = 1'b0;
		case (paddr)
			OFS_CTRL:   next_rdata[CTRL_W-1:0] = ctrl;
			OFS_STATUS: next_rdata[ST_W-1:0] = status;
			OFS_MASK:   next_rdata[ST_W-1:0] = mask;
			OFS_LAST: begin
				next_rdata[DATA_W-1:0] = data_out;
				next_rdata[LAST_FLAG]  = range_flag;
			end
			OFS_COUNT:  next_rdata = sample_count;
			default:    next_err = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= RD_ZERO;
		end else begin
			pready  <= setup;
			pslverr <= setup & next_err;
			prdata  <= (setup && !pwrite) ? next_rdata : RD_ZERO;
		end
	end

	// Checks
	sequence update_seq;
		!sample_clock_out_true && sample_clock_out_comp;
	endsequence

	sequence release_seq;
		sample_clock_out_true && !sample_clock_out_comp;
	endsequence

	clk_pair_a: assert property (sample_clock_out_comp == !sample_clock_out_true) // see R03
		else $error("output clock pair not complementary");

	update_edge_a: assert property (strobe_rise |=> update_seq) // see R04
		else $error("true clock did not fall with data update");

	release_edge_a: assert property (strobe_fall |=> release_seq) // see R03
		else $error("true clock did not rise after strobe fall");

	data_hold_a: assert property ($changed(data_out) |-> $past(strobe_rise)) // see R01
		else $error("data changed without a strobe");

	range_flag_a: assert property (strobe_rise |=> range_flag == |$past(range_s2)) // see R02
		else $error("range flag does not match sampled range");

	scram_lsb_a: assert property (data_out[0] == plain_word[0]) // see R09
		else $error("scrambling altered the lsb");

	scram_off_a: assert property (strobe_rise && !scramble_enable |=> // see R10
		data_out == plain_word)
		else $error("word scrambled while disabled");

	scram_on_a: assert property (strobe_rise && scramble_enable |=> // see R07
		data_out[DATA_W-1:1] == (plain_word[DATA_W-1:1] ^ {(DATA_W-1){plain_word[0]}}))
		else $error("scrambled bits wrong");

	dither_off_a: assert property (!dither_enable |=> dither_dac == '0) // see R11
		else $error("dither active while disabled");

	dither_sub_a: assert property (strobe_rise && dither_enable |=> // see R12
		plain_word == ados_format(DATA_W'($past(result_s2) - $past(dither_sub)),
		$past(format_twos)))
		else $error("dither not subtracted");

	format_a: assert property (strobe_rise && !dither_enable && format_twos |=> // see R13
		{~plain_word[DATA_W-1], plain_word[DATA_W-2:0]} == $past(result_s2))
		else $error("two's complement format wrong");

	aligned_a: assert property ($changed(range_flag) |-> $past(strobe_rise) // see R14
		&& !sample_clock_out_true)
		else $error("flag moved apart from clock pair");

	apb_ready_a: assert property (setup |=> pready ##1 !pready)
		else $error("ready not a single access cycle");

	irq_level_a: assert property (irq == |($past(status) & $past(mask)))
		else $error("interrupt level mismatch");

	// Register and status checks
	status_set_a: assert property (strobe_rise |=> status[ST_SAMPLE])
		else $error("sample event lost");

	range_event_a: assert property (strobe_rise && (|range_s2) |=> status[ST_RANGE]) // see R02
		else $error("range event lost");

	status_clr_a: assert property (status_clr[ST_RANGE] && !status_set[ST_RANGE] |=>
		!status[ST_RANGE])
		else $error("range event not cleared");

	count_clear_a: assert property (wr_go && paddr == OFS_COUNT |=> sample_count == RD_ZERO)
		else $error("sample count not cleared");

	count_step_a: assert property (strobe_rise && !(wr_go && paddr == OFS_COUNT) |=> // see R01
		sample_count == $past(sample_count) + 32'h0000_0001)
		else $error("sample count did not step");

	ctrl_write_a: assert property (wr_go && paddr == OFS_CTRL |=> // see R10
		ctrl == CTRL_W'($past(pwdata)))
		else $error("control write lost");

	mask_write_a: assert property (wr_go && paddr == OFS_MASK |=> mask == ST_W'($past(pwdata)))
		else $error("mask write lost");

	rdata_idle_a: assert property (!pready |-> prdata == RD_ZERO)
		else $error("read data outside access cycle");

	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");

	misalign_err_a: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr)
		else $error("misaligned access not refused");
endmodule : ados_output_stage

// File: test/ados_capture_model.sv
// Capture logic model on the far side of the output stage.
// Assumes the word is stable at the rise of the true output clock.
`timescale 1ns/10ps
module ados_capture_model
	import ados_pkg::*;
(
	input  wire logic              clk_true,
	input  wire logic              descramble,
	input  wire logic [DATA_W-1:0] data_in,
	input  wire logic              flag_in,
	output logic      [DATA_W-1:0] cap_word,
	output logic                   cap_flag,
	output int                     cap_count
);
	int count = 0;

	assign cap_count = count;

	// Latch on true clock rise, never on the strobe
	always @(posedge clk_true) begin
		cap_word <= descramble ? (data_in ^ {{(DATA_W-1){data_in[0]}}, 1'h0}) : data_in;
		cap_flag <= flag_in;
		count    <= count + 1;
	end
endmodule : ados_capture_model

// File: test/tb.sv
// Testbench for the output stage, with a capture model on its outputs.
// Assumes a free-running 5 MHz strobe unrelated in phase to pclk.
`timescale 1ns/10ps
module tb
	import ados_pkg::*;
;
	logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [ADDR_W-1:0]   paddr;
	logic [31:0]         pwdata, prdata, rd;
	logic                strobe, over, under, flag, ctrue, ccomp, cflag, desc;
	logic [DATA_W-1:0]   result, dout, cword;
	logic [DITHER_W-1:0] dac, d1;
	int                  ccount, fail_count, comparisons;

	ados_output_stage DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .sample_strobe_in(strobe), .conv_result(result),
		.conv_over(over), .conv_under(under), .data_out(dout), .range_flag(flag),
		.sample_clock_out_true(ctrue), .sample_clock_out_comp(ccomp), .dither_dac(dac));

	ados_capture_model cap (.clk_true(ctrue), .descramble(desc), .data_in(dout),
		.flag_in(flag), .cap_word(cword), .cap_flag(cflag), .cap_count(ccount));

	initial begin
		pclk = 1'h0;
		forever #12.5 pclk = ~pclk;
	end

	initial begin
		strobe = 1'h0;
		#37;
		forever #100 strobe = ~strobe;
	end

	task tally_and_finish;
		$display("mismatches %0d, comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (n >= 20) begin
			fail_count++;
			$display("wrong value at %0t: no ready", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task sample(input logic [15:0] v, input logic o, input logic u);
		int c, n;
		@(negedge strobe);
		@(posedge pclk);
		result <= v;
		over <= o;
		under <= u;
		c = ccount;
		n = 0;
		@(posedge strobe);
		d1 = dac;
		while (ccount < c + 2 && n < 100) begin
			n++;
			@(posedge pclk);
		end
		if (n >= 100) begin
			fail_count++;
			$display("wrong value at %0t: no capture", $time);
		end
		chk(ccomp, !ctrue, "clock pair");
	endtask : sample

	task t_plain;
		logic [15:0] v [4];
		v = '{16'h1234, 16'hFFFF, 16'h0000, 16'h8001};
		apb(1'h0, OFS_CTRL, 32'h0);
		chk(rd, CTRL_RESET, "ctrl reset");
		for (int i = 0; i < 4; i++) begin
			sample(v[i], i == 1, i == 2);
			chk(cword, v[i], "plain word");
			chk(cflag, i == 1 || i == 2, "range flag");
		end
		apb(1'h0, OFS_LAST, 32'h0);
		chk(rd, 32'h0000_8001, "last word");
		$display("plain test done");
	endtask : t_plain

	task t_format;
		apb(1'h1, OFS_CTRL, 32'h2);
		sample(16'h1234, 1'h0, 1'h0);
		chk(cword, 16'h9234, "twos word");
		sample(16'h8000, 1'h0, 1'h0);
		chk(cword, 16'h0000, "twos zero");
		$display("format test done");
	endtask : t_format

	task t_scramble;
		apb(1'h1, OFS_CTRL, 32'h1);
		desc <= 1'h1;
		sample(16'hA5C3, 1'h1, 1'h0);
		chk(dout, 16'h5A3D, "scrambled word");
		chk(cword, 16'hA5C3, "descrambled word");
		chk(cflag, 1'h1, "flag under scramble");
		sample(16'h1234, 1'h0, 1'h0);
		chk(dout, 16'h1234, "even word");
		apb(1'h1, OFS_CTRL, 32'h3);
		sample(16'h0001, 1'h0, 1'h0);
		chk(dout, 16'h7FFF, "format then scramble");
		apb(1'h1, OFS_CTRL, 32'h0);
		desc <= 1'h0;
		sample(16'hA5C3, 1'h0, 1'h0);
		chk(dout, 16'hA5C3, "scramble off");
		$display("scramble test done");
	endtask : t_scramble

	task t_dither;
		logic [15:0] ex;
		logic [7:0]  e;
		apb(1'h1, OFS_CTRL, 32'h4);
		sample(16'h4000, 1'h0, 1'h0);
		chk(d1, LFSR_SEED[DITHER_W-1:0], "dither seed");
		ex = 16'h4000 - {8'h00, d1};
		chk(dout, ex, "dithered word");
		e = d1;
		sample(16'h4000, 1'h0, 1'h0);
		chk(d1 != e, 1'h1, "dither static");
		apb(1'h1, OFS_CTRL, 32'h0);
		sample(16'h4000, 1'h0, 1'h0);
		chk(dac, 8'h00, "dither off");
		chk(dout, 16'h4000, "undithered word");
		$display("dither test done");
	endtask : t_dither

	task t_irq;
		apb(1'h1, OFS_MASK, 32'h2);
		apb(1'h1, OFS_STATUS, 32'h3);
		sample(16'h0100, 1'h1, 1'h0);
		chk(irq, 1'h1, "irq on range");
		sample(16'h0100, 1'h0, 1'h0);
		apb(1'h0, OFS_STATUS, 32'h0);
		chk(rd[ST_RANGE], 1'h1, "range event");
		apb(1'h1, OFS_STATUS, 32'h2);
		apb(1'h0, OFS_STATUS, 32'h0);
		chk(rd[ST_RANGE], 1'h0, "range cleared");
		chk(irq, 1'h0, "irq cleared");
		sample(16'h0100, 1'h0, 1'h1);
		apb(1'h1, OFS_MASK, 32'h0);
		apb(1'h0, OFS_MASK, 32'h0);
		chk(irq, 1'h0, "irq masked");
		chk(rd, 32'h0, "mask readback");
		apb(1'h0, 8'h20, 32'h0);
		chk(err, 1'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		$display("interrupt test done");
	endtask : t_irq

	task t_count;
		logic [31:0] r0;
		apb(1'h1, OFS_COUNT, 32'h0);
		apb(1'h0, OFS_COUNT, 32'h0);
		r0 = rd;
		chk(r0 < 32'h2, 1'h1, "count cleared");
		sample(16'h0100, 1'h0, 1'h0);
		sample(16'h0100, 1'h0, 1'h0);
		apb(1'h0, OFS_COUNT, 32'h0);
		chk(rd - r0 >= 32'h2 && rd - r0 <= 32'h5, 1'h1, "count advanced");
		$display("count test done");
	endtask : t_count

	initial begin
		#400_000;
		fail_count++;
		$display("wrong value at %0t: watchdog expired", $time);
		tally_and_finish();
	end

	initial begin
		{presetn, psel, penable, pwrite, over, under, desc} = 7'h0;
		paddr = '0;
		pwdata = '0;
		result = '0;
		fail_count = 0;
		comparisons = 0;
		repeat (16) @(posedge pclk);
		chk(dout, 16'h0, "reset word");
		chk({ctrue, ccomp, flag, irq}, 4'h8, "reset clocks");
		chk(dac, 8'h0, "reset dither");
		presetn <= 1'h1;
		t_plain();
		t_format();
		t_scramble();
		t_dither();
		t_irq();
		t_count();
		tally_and_finish();
	end
endmodule : tb
